// ### core/ssp_pkg.sv
// Constants for the 8-bit synchronous serial port.
// Assumes an APB slave with 32-bit data, one register per word.
package ssp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0]  SSP_IDX_LO  = 10'h0e5;
  localparam logic [9:0]  SSP_IDX_HI  = 10'h0e6;
  localparam logic [9:0]  SSP_IDX_CT  = 10'h0e7;
  localparam logic [9:0]  SSP_IDX_DM  = 10'h0e9;
  localparam logic [9:0]  SSP_IDX_FL  = 10'h0ec;
  localparam logic [11:0] SSP_ADR_LO  = {SSP_IDX_LO, 2'b00};
  localparam logic [11:0] SSP_ADR_HI  = {SSP_IDX_HI, 2'b00};
  localparam logic [11:0] SSP_ADR_CT  = {SSP_IDX_CT, 2'b00};
  localparam logic [11:0] SSP_ADR_DM  = {SSP_IDX_DM, 2'b00};
  localparam logic [11:0] SSP_ADR_FL  = {SSP_IDX_FL, 2'b00};

  // Control register fields
  localparam int SSP_B_CSLO = 0;
  localparam int SSP_B_CSHI = 1;
  localparam int SSP_B_SEN  = 2;
  localparam int SSP_B_TRIG = 3;
  // Direction / mask register fields
  localparam int SSP_B_IEN  = 0;
  localparam int SSP_B_DIR  = 1;
  // Flag register field
  localparam int SSP_B_DONE = 0;

  typedef enum logic [1:0] {
    SSP_SLAVE  = 2'b00,
    SSP_UNUSED = 2'b01,
    SSP_MCLK   = 2'b10,
    SSP_MCLK2  = 2'b11
  } ssp_mode_t;

  typedef enum logic {
    SSP_IDLE = 1'b0,
    SSP_RUN  = 1'b1
  } ssp_state_t;

  // Reset values
  localparam ssp_mode_t SSP_MODE_RST = SSP_SLAVE;
  localparam logic      SSP_SEN_RST  = 1'b0;
  localparam logic      SSP_IEN_RST  = 1'b0;
  localparam logic      SSP_DIR_RST  = 1'b0;

  // Master half period in system cycles, minus one
  localparam logic [1:0] SSP_HALF_FAST = 2'h0;
  localparam logic [1:0] SSP_HALF_SLOW = 2'h1;
  localparam logic [3:0] SSP_LAST_BIT  = 4'h7;

endpackage : ssp_pkg

// ### core/ssp_top.sv
// 8-bit synchronous serial port with APB register access.
// Assumes pin inputs already synchronous to i_clk.
`timescale 1ns/100ps

// What this block does
// - One 8-bit shift register for both directions
// - Two-bit select: slave, master CLK, CLK/2
// - Reset selects slave with external clock
// - Master drives exactly eight clocks, then stops
// - Slave ignores clocks after eighth until trigger
// - Eight counted clocks complete the transfer
// - Load nibbles, write trigger, data shifts out
// - Output bit changes on serial clock rise
// - Sample on fall or rise by edge select
// - Done flag always set; irq gated by mask
// - Direction 1 drives mode pin high in PIN_CFG 8 to 10
// - Direction 0 drives mode pin low
// - Received byte readable through both nibbles
// - Slave ready low when port may transfer
// - Ready falls on trigger, rises on clock low
// - High nibble access returns ready high
// - Bit order is a build-time parameter
// - Pin assignment is one of 14 configurations
// - Trigger position reads back running status
// - Done flag clears on read; writes ignored
module ssp_top
  import ssp_pkg::*;
#(
  parameter bit LSB_FIRST = 1'b1,
  parameter int PIN_CFG   = 3
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  input  wire logic        i_sclk,
  input  wire logic        i_sin,
  input  wire logic        i_sio,
  output logic             o_sclk_n,
  output logic             o_sclk_oe,
  output logic             o_serial_data_out_pin,
  output logic             o_sio,
  output logic             o_sio_oe,
  output logic             o_mode,
  output logic             o_ready_n,
  output logic             o_irq
);

  function automatic logic [7:0] ssp_shift(
    input logic [7:0] sh,
    input logic       b
  );
    if (LSB_FIRST) begin
      ssp_shift = {b, sh[7:1]};
    end else begin
      ssp_shift = {sh[6:0], b};
    end
  endfunction : ssp_shift

  function automatic logic ssp_outbit(input logic [7:0] sh);
    ssp_outbit = LSB_FIRST ? sh[0] : sh[7];
  endfunction : ssp_outbit

  // Pin assignment decode
  wire ser_on   = (PIN_CFG >= 3) && (PIN_CFG <= 14);
  wire use_sio  = (PIN_CFG >= 8) && (PIN_CFG <= 14);
  wire has_serial_data_out_pin = (PIN_CFG >= 3) && (PIN_CFG <= 5);
  wire has_mode = (PIN_CFG >= 8) && (PIN_CFG <= 10);
  wire has_rdy  = (PIN_CFG == 3) || (PIN_CFG == 8) ||
                  (PIN_CFG == 11) || (PIN_CFG == 12);

  logic [7:0]  sh_r;
  logic [7:0]  sh_nxt;
  ssp_mode_t   mode_r;
  ssp_state_t  st_r;
  logic        sen_r;
  logic        ien_r;
  logic        dir_r;
  logic        done_r;
  logic        done_nxt;
  logic [3:0]  cnt_r;
  logic        smp_r;
  logic        rdy_n_r;
  logic        sclk_n_r;
  logic [1:0]  div_r;
  logic        sclk_q_r;
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        slverr_r;
  logic        irq_r;
  logic        serial_data_out_pin_r;
  logic        sio_r;
  logic        sio_oe_r;
  logic        mode_pin_r;
  logic        sclk_oe_r;

  // APB decode
  wire access = i_psel & i_penable;
  wire fin    = access & pready_r;
  wire wr     = fin & i_pwrite;
  wire rd     = fin & ~i_pwrite;
  wire hit_lo = (i_paddr == SSP_ADR_LO);
  wire hit_hi = (i_paddr == SSP_ADR_HI);
  wire hit_ct = (i_paddr == SSP_ADR_CT);
  wire hit_dm = (i_paddr == SSP_ADR_DM);
  wire hit_fl = (i_paddr == SSP_ADR_FL);
  wire mapped = hit_lo | hit_hi | hit_ct | hit_dm | hit_fl;

  wire running = (st_r == SSP_RUN);
  wire master  = mode_r[1];
  wire slave   = (mode_r == SSP_SLAVE);

  wire [31:0] rdata_nxt =
    hit_lo ? {28'h000_0000, sh_r[3:0]} :
    hit_hi ? {28'h000_0000, sh_r[7:4]} :
    hit_ct ? {28'h000_0000, running, sen_r, mode_r} :
    hit_dm ? {28'h000_0000, 2'b00, dir_r, ien_r} :
    hit_fl ? {28'h000_0000, 3'b000, done_r} :
             32'h0000_0000;

  // Trigger uses the mode written in the same access
  wire [1:0] wmode = i_pwdata[SSP_B_CSHI:SSP_B_CSLO];
  wire trig = wr & hit_ct & i_pwdata[SSP_B_TRIG] & ~running &
              (wmode != SSP_UNUSED) & ser_on;
  wire trig_slave = trig & (wmode == SSP_SLAVE);

  // Master clock generator
  wire [1:0] half = (mode_r == SSP_MCLK2) ? SSP_HALF_SLOW
                                          : SSP_HALF_FAST;
  wire tick   = running & master & (div_r == 2'h0);
  wire m_fall = tick & sclk_n_r;
  wire m_rise = tick & ~sclk_n_r;

  // Slave clock edges, masked outside a transfer
  wire s_fall = sclk_q_r & ~i_sclk;
  wire s_rise = ~sclk_q_r & i_sclk;

  wire fall = running & (master ? m_fall : (slave & s_fall));
  wire rise = running & (master ? m_rise : (slave & s_rise));

  wire rx     = use_sio ? i_sio : i_sin;
  wire bit_in = sen_r ? smp_r : rx;
  wire last   = rise & (cnt_r == SSP_LAST_BIT);

  assign sh_nxt =
    rise           ? ssp_shift(sh_r, bit_in) :
    (wr & hit_lo)  ? {sh_r[7:4], i_pwdata[3:0]} :
    (wr & hit_hi)  ? {i_pwdata[3:0], sh_r[3:0]} :
                     sh_r;

  wire rd_clr = rd & hit_fl & prdata_r[SSP_B_DONE];
  assign done_nxt = last | (done_r & ~rd_clr);

  wire hi_touch = fin & hit_hi;

  // APB slave: one wait state, registered answer
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end else begin
      pready_r <= access & ~pready_r;
      prdata_r <= (access & ~pready_r) ? rdata_nxt : prdata_r;
      slverr_r <= access & ~pready_r & ~mapped;
    end
  end

  // Configuration registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_r <= SSP_MODE_RST;
      sen_r  <= SSP_SEN_RST;
      ien_r  <= SSP_IEN_RST;
      dir_r  <= SSP_DIR_RST;
    end else begin
      if (wr & hit_ct) begin
        mode_r <= ssp_mode_t'(wmode);
        sen_r  <= i_pwdata[SSP_B_SEN];
      end
      if (wr & hit_dm) begin
        ien_r <= i_pwdata[SSP_B_IEN];
        dir_r <= i_pwdata[SSP_B_DIR];
      end
    end
  end

  // Transfer sequencing
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r   <= SSP_IDLE;
      cnt_r  <= 4'h0;
      done_r <= 1'b0;
      sh_r   <= 8'h00;
      smp_r  <= 1'b0;
    end else begin
      case (st_r)
        SSP_IDLE: begin
          if (trig) begin
            st_r  <= SSP_RUN;
            cnt_r <= 4'h0;
          end
        end
        SSP_RUN: begin
          if (last) begin
            st_r <= SSP_IDLE;
          end
          if (rise) begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        default: st_r <= SSP_IDLE;
      endcase
      done_r <= done_nxt;
      sh_r   <= sh_nxt;
      smp_r  <= fall ? rx : smp_r;
    end
  end

  // Serial clock and pins
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sclk_n_r  <= 1'b1;
      div_r     <= 2'h0;
      sclk_q_r  <= 1'b1;
      sclk_oe_r <= 1'b0;
    end else begin
      sclk_q_r  <= i_sclk;
      sclk_oe_r <= master & ser_on;
      if (!running || !master) begin
        sclk_n_r <= 1'b1;
        div_r    <= half;
      end else if (tick) begin
        sclk_n_r <= ~sclk_n_r;
        div_r    <= half;
      end else begin
        div_r <= div_r - 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      serial_data_out_pin_r     <= 1'b1;
      sio_r      <= 1'b1;
      sio_oe_r   <= 1'b0;
      mode_pin_r <= 1'b0;
      rdy_n_r    <= 1'b1;
      irq_r      <= 1'b0;
    end else begin
      serial_data_out_pin_r     <= has_serial_data_out_pin ? ssp_outbit(sh_nxt) : 1'b1;
      sio_r      <= ssp_outbit(sh_nxt);
      sio_oe_r   <= use_sio & dir_r;
      mode_pin_r <= has_mode & dir_r;
      if (trig_slave & has_rdy) begin
        rdy_n_r <= 1'b0;
      end else if ((running & slave & s_fall) | hi_touch) begin
        rdy_n_r <= 1'b1;
      end
      irq_r <= done_r & ien_r;
    end
  end

  assign o_pready  = pready_r;
  assign o_prdata  = prdata_r;
  assign o_pslverr = slverr_r;
  assign o_sclk_n  = sclk_n_r;
  assign o_sclk_oe = sclk_oe_r;
  assign o_serial_data_out_pin    = serial_data_out_pin_r;
  assign o_sio     = sio_r;
  assign o_sio_oe  = sio_oe_r;
  assign o_mode    = mode_pin_r;
  assign o_ready_n = rdy_n_r;
  assign o_irq     = irq_r;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  a_mode_reset: assert property (
    $past(i_sys_rst) |-> mode_r == SSP_SLAVE && !sen_r)
    else $error("mode not slave after reset");

  a_done_eight: assert property (
    last |=> done_r && st_r == SSP_IDLE && cnt_r == 4'h8)
    else $error("transfer not ended at eighth clock");

  a_master_idle: assert property (
    st_r == SSP_IDLE ##1 st_r == SSP_IDLE |-> o_sclk_n)
    else $error("master clock low while idle");

  a_slave_mask: assert property (
    st_r == SSP_IDLE && !trig |=> $stable(cnt_r))
    else $error("clock counted while idle");

  a_ready_fall: assert property (
    trig_slave && has_rdy |=> !o_ready_n ##1 1)
    else $error("ready not low after trigger");

  a_ready_touch: assert property (
    hi_touch && !trig |=> o_ready_n)
    else $error("ready not high after nibble access");

  a_irq_mask: assert property (
    o_irq |-> $past(ien_r) && $past(done_r))
    else $error("interrupt without mask enable");

  a_run_status: assert property (
    access && !pready_r && hit_ct |=>
      o_prdata[SSP_B_TRIG] == $past(running))
    else $error("status bit wrong");

  a_done_clear: assert property (
    rd_clr && !last |=> !done_r)
    else $error("done flag not cleared by read");

  a_bit_count: assert property (
    rise |=> cnt_r == $past(cnt_r) + 4'h1)
    else $error("clock count did not advance");

  a_ready_clock: assert property (
    running && slave && s_fall |=> o_ready_n)
    else $error("ready not high after clock low");

  a_serial_data_out_pin_steady: assert property (
    !$past(i_sys_rst) && !rise && !(wr && (hit_lo || hit_hi))
      |=> $stable(o_serial_data_out_pin))
    else $error("serial out moved without clock rise");

  a_dir_out: assert property (
    wr && hit_dm && i_pwdata[SSP_B_DIR] |->
      ##2 o_mode == has_mode && o_sio_oe == use_sio)
    else $error("direction pin not high for output");

  a_dir_in: assert property (
    wr && hit_dm && !i_pwdata[SSP_B_DIR] |-> ##2 !o_mode && !o_sio_oe)
    else $error("direction pin not low for input");

endmodule : ssp_top

// ### verif/ssp_peer.sv
// Far-side serial device: master clock source or slave responder.
// Assumes LSB-first framing; pins change just after i_clk edges.
`timescale 1ns/100ps
module ssp_peer (
  input  wire logic       i_clk,
  input  wire logic       i_sclk_n,
  input  wire logic       i_serial_data_out_pin,
  input  wire logic [7:0] i_tx,
  output logic            o_sclk,
  output logic            o_sin,
  output logic [7:0]      o_rx,
  output int              o_falls
);
  initial begin
    o_sclk  = 1'b1;
    o_sin   = 1'b0;
    o_rx    = 8'h00;
    o_falls = 0;
  end

  // Slave role of the peer: follow the port's clock
  // Port clock toggles only as master, so no enable gate
  always @(negedge i_sclk_n) begin
    o_rx    <= {i_serial_data_out_pin, o_rx[7:1]};
    o_sin   <= i_tx[o_falls[2:0]];
    o_falls <= o_falls + 1;
  end

  // Master role: n clocks, 4 system cycles per phase
  task automatic shift(input logic [7:0] b, input logic sample_edge_select, input int n);
    for (int k = 0; k < n; k++) begin
      if (sample_edge_select)
        o_sin <= b[k];
      repeat (3) @(posedge i_clk);
      o_rx   <= {i_serial_data_out_pin, o_rx[7:1]};
      o_sclk <= 1'b0;
      repeat (2) @(posedge i_clk);
      if (!sample_edge_select)
        o_sin <= b[k];
      repeat (2) @(posedge i_clk);
      o_sclk <= 1'b1;
      @(posedge i_clk);
    end
    // Released line shows no stale bit
    o_sin <= ~o_sin;
  endtask : shift
endmodule : ssp_peer

// ### verif/sync_serial_8bit_port_test.sv
// Testbench for the serial port: APB register tasks plus serial peer.
// Assumes PIN_CFG 3 for the main port; a second port in PIN_CFG 8
// shares the bus and shows the shared data and direction pins.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module sync_serial_8bit_port_test;
  import ssp_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        sclk, serial_data_in_pin, sclk_n, sclk_oe, serial_data_out_pin, ready_n, irq;
  logic        shared_bidir_data_pin, sio_oe, mode, sio2, sio_oe2, mode2;
  logic [7:0]  rx, tx, mb;
  int          falls, f0, error_cnt, samples_checked;

  ssp_top #(.LSB_FIRST(1'b1), .PIN_CFG(3)) ssp_top_inst (
    .i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_sclk(sclk), .i_sin(serial_data_in_pin), .i_sio(1'b0), .o_sclk_n(sclk_n),
    .o_sclk_oe(sclk_oe), .o_serial_data_out_pin(serial_data_out_pin), .o_sio(shared_bidir_data_pin), .o_sio_oe(sio_oe),
    .o_mode(mode), .o_ready_n(ready_n), .o_irq(irq));
  ssp_top #(.LSB_FIRST(1'b1), .PIN_CFG(8)) ssp_top_sio_inst (
    .i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(), .o_prdata(), .o_pslverr(),
    .i_sclk(sclk), .i_sin(1'b0), .i_sio(serial_data_in_pin), .o_sclk_n(),
    .o_sclk_oe(), .o_serial_data_out_pin(), .o_sio(sio2), .o_sio_oe(sio_oe2),
    .o_mode(mode2), .o_ready_n(), .o_irq());
  ssp_peer ssp_peer_inst (
    .i_clk(clk), .i_sclk_n(sclk_n), .i_serial_data_out_pin(serial_data_out_pin),
    .i_tx(tx), .o_sclk(sclk), .o_sin(serial_data_in_pin), .o_rx(rx), .o_falls(falls));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = pslverr ? 32'hFFFF_FFFF : prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    `CHK(rdat, e)
  endtask : rdc

  task automatic wait_done();
    do begin
      apb(SSP_ADR_FL, 1'b0, 32'h0000_0000);
    end while (rdat !== 32'h0000_0001);
    `CHK(rdat, 32'h0000_0001)
  endtask : wait_done

  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, tx} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc(SSP_ADR_CT, 32'h0000_0000);
    `CHK({ready_n, sclk_n, sclk_oe}, 3'b110)
    `CHK({mode2, sio_oe2, mode, sio_oe}, 4'b0000)
    rdc(12'h004, 32'hFFFF_FFFF);
    // Slave receive, rising-edge sampling
    apb(SSP_ADR_LO, 1'b1, 32'h0000_0005);
    apb(SSP_ADR_HI, 1'b1, 32'h0000_000A);
    apb(SSP_ADR_CT, 1'b1, 32'h0000_0008);
    rdc(SSP_ADR_CT, 32'h0000_0008);
    `CHK(ready_n, 1'b0)
    ssp_peer_inst.shift(8'h3C, 1'b0, 8);
    `CHK(ready_n, 1'b1)
    wait_done();
    `CHK(rx, 8'hA5)
    rdc(SSP_ADR_FL, 32'h0000_0000);
    rdc(SSP_ADR_LO, 32'h0000_000C);
    rdc(SSP_ADR_HI, 32'h0000_0003);
    `CHK(irq, 1'b0)
    // Clocks after the eighth are ignored
    ssp_peer_inst.shift(8'hFF, 1'b0, 8);
    rdc(SSP_ADR_LO, 32'h0000_000C);
    rdc(SSP_ADR_FL, 32'h0000_0000);
    // Falling-edge sampling, irq enabled, ready forced high
    apb(SSP_ADR_DM, 1'b1, 32'h0000_0003);
    rdc(SSP_ADR_DM, 32'h0000_0003);
    `CHK({mode2, sio_oe2, mode, sio_oe}, 4'b1100)
    apb(SSP_ADR_CT, 1'b1, 32'h0000_000C);
    rdc(SSP_ADR_CT, 32'h0000_000C);
    `CHK(ready_n, 1'b0)
    apb(SSP_ADR_HI, 1'b0, 32'h0000_0000);
    repeat (2) @(posedge clk);
    `CHK(ready_n, 1'b1)
    ssp_peer_inst.shift(8'h96, 1'b1, 8);
    repeat (6) @(posedge clk);
    `CHK(irq, 1'b1)
    wait_done();
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    rdc(SSP_ADR_LO, 32'h0000_0006);
    rdc(SSP_ADR_HI, 32'h0000_0009);
    // Unused mode refuses the trigger
    apb(SSP_ADR_CT, 1'b1, 32'h0000_0009);
    apb(SSP_ADR_CT, 1'b0, 32'h0000_0000);
    `CHK(rdat[3], 1'b0)
    // Master with system clock, then with half clock
    for (int m = 2; m < 4; m++) begin
      f0 = falls;
      mb = (m == 2) ? 8'h81 : 8'h7E;
      tx = ~mb;
      apb(SSP_ADR_LO, 1'b1, {28'h0, mb[3:0]});
      apb(SSP_ADR_HI, 1'b1, {28'h0, mb[7:4]});
      apb(SSP_ADR_CT, 1'b1, 32'h0000_0008 | m);
      wait_done();
      `CHK(falls - f0, 8)
      `CHK(rx, mb)
      `CHK({sclk_n, sclk_oe}, 2'b11)
      `CHK({shared_bidir_data_pin, sio2}, {2{tx[0]}})
      rdc(SSP_ADR_LO, {28'h0, tx[3:0]});
      rdc(SSP_ADR_HI, {28'h0, tx[7:4]});
    end
    // Direction back to input drops both direction pins
    apb(SSP_ADR_DM, 1'b1, 32'h0000_0001);
    rdc(SSP_ADR_DM, 32'h0000_0001);
    `CHK({mode2, sio_oe2, mode, sio_oe}, 4'b0000)
    tally_and_finish();
  end
endmodule : sync_serial_8bit_port_test
